/* logic/flow_pkg.sv */
// Operation
// (R1) act on valid flow frames when enabled
// (R2) inhibit transmitter for received pause time
// (R3) forward pause frame flagged for discard
// (R4) send pause frame after current packet
// (R5) place client pause value in frame
// (R6) all flow signals active high
// (R7) priority ports only with priority option
// (R8) legacy pause and priority never together
// (R9) eight request channels, priorities 0 to 7
// (R10) priority request sends frame next opportunity
// (R11) drive per-priority pause to receive fifo
// (R12) quanta expire only after fifo acknowledge
// (R13) unused acknowledge tied high by client
// (R14) act only on good addressed pause frames
// (R15) capture pause value with the request
// (R16) hold indication until quanta expire
package flow_pkg;
  // ==========================================================
  // frame constants
  localparam logic [15:0] CTRL_LTYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [15:0] PFC_OPCODE = 16'h0101;
  localparam logic [47:0] CTRL_MCAST = 48'h0180c2000001;
  localparam int QUANTA_W = 16;
  localparam int NUM_PRI = 8;
  // ==========================================================
  // timing: one quantum is 512 bit times at 1 ns per bit
  localparam int QUANTUM_NS = 512;
  localparam int CLK_NS = 8;
  localparam int QUANTUM_CYCLES = (QUANTUM_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRE_W = $clog2(QUANTUM_CYCLES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(QUANTUM_CYCLES - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = '0;
  localparam logic [QUANTA_W-1:0] QUANTA_ZERO = '0;
  localparam logic [QUANTA_W-1:0] QUANTA_ONE = 16'h0001;
endpackage

`timescale 1ns/10ps
// ==========================================================
// quanta countdown, starts once run is seen after a load
module quanta_timer
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [flow_pkg::QUANTA_W-1:0] quanta,
  input wire logic run,
  output logic busy
);
  logic [flow_pkg::QUANTA_W-1:0] cnt_q, cnt_d;
  logic [flow_pkg::PRE_W-1:0] pre_q, pre_d;
  logic started_q, started_d;

  always_comb
  begin
    cnt_d = cnt_q;
    pre_d = pre_q;
    started_d = started_q;
    if (load)
    begin
      cnt_d = quanta;
      pre_d = flow_pkg::PRE_ZERO;
      started_d = 1'b0;
    end
    else if (cnt_q != flow_pkg::QUANTA_ZERO && (run || started_q)) // see (R12)
    begin
      started_d = 1'b1;
      if (pre_q == flow_pkg::PRE_LAST)
      begin
        pre_d = flow_pkg::PRE_ZERO;
        cnt_d = cnt_q - flow_pkg::QUANTA_ONE;
      end
      else
      begin
        pre_d = pre_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      pre_q <= '0;
      started_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      started_q <= started_d;
    end
  end

  assign busy = (cnt_q != flow_pkg::QUANTA_ZERO); // see (R16)
endmodule

/* logic/mac_flow_control_pause.sv */
`timescale 1ns/10ps
module mac_flow_control_pause
#(
  parameter bit PFC_ENABLE = 1'b0,
  parameter int NUM_PRI = flow_pkg::NUM_PRI
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_rx_fc_enable,
  input wire logic [47:0] cfg_src_addr,
  input wire logic pause_req,
  input wire logic [flow_pkg::QUANTA_W-1:0] pause_val,
  input wire logic tx_frame_active,
  input wire logic tx_ctrl_grant,
  input wire logic rx_frame_done,
  input wire logic rx_frame_good,
  input wire logic [47:0] rx_frame_da,
  input wire logic [15:0] rx_frame_ltype,
  input wire logic [15:0] rx_frame_opcode,
  input wire logic [flow_pkg::QUANTA_W-1:0] rx_frame_quanta,
  input wire logic [NUM_PRI-1:0] rx_frame_pri_enable,
  input wire logic [NUM_PRI*flow_pkg::QUANTA_W-1:0] rx_frame_pri_quanta,
  input wire logic [NUM_PRI-1:0] tx_priority_pause_request_n,
  input wire logic [NUM_PRI-1:0] rx_priority_pause_ack_n,
  output logic tx_pause_send,
  output logic [flow_pkg::QUANTA_W-1:0] tx_pause_param,
  output logic tx_pfc_send,
  output logic [NUM_PRI-1:0] tx_pfc_vector,
  output logic tx_inhibit,
  output logic rx_frame_drop,
  output logic [NUM_PRI-1:0] rx_priority_pause_indication_n
);
  // names ending _n on the priority ports are channel indices; every flow signal is high-active, arst_n is low-active, see (R6)

  // ==========================================================
  // reset release
  logic [1:0] rst_q;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_q <= 2'b00;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  // ==========================================================
  // received control frame decode
  function automatic logic ctrl_ok(input logic good, input logic [47:0] da,
                                   input logic [15:0] ltype, input logic [15:0] op,
                                   input logic [15:0] want_op, input logic [47:0] sa);
    ctrl_ok = good && ltype == flow_pkg::CTRL_LTYPE && op == want_op
              && (da == flow_pkg::CTRL_MCAST || da == sa); // see (R14)
  endfunction

  logic legacy_hit;
  logic pfc_hit;

  assign legacy_hit = !PFC_ENABLE && rx_frame_done && cfg_rx_fc_enable // see (R1) (R8)
                      && ctrl_ok(rx_frame_good, rx_frame_da, rx_frame_ltype,
                                 rx_frame_opcode, flow_pkg::PAUSE_OPCODE, cfg_src_addr);
  assign pfc_hit = PFC_ENABLE && rx_frame_done && cfg_rx_fc_enable // see (R1) (R8)
                   && ctrl_ok(rx_frame_good, rx_frame_da, rx_frame_ltype,
                              rx_frame_opcode, flow_pkg::PFC_OPCODE, cfg_src_addr);

  // ==========================================================
  // transmit side requests
  logic pause_req_q, pause_req_d;
  logic pause_pend_q, pause_pend_d;
  logic [flow_pkg::QUANTA_W-1:0] pause_param_q, pause_param_d;
  logic pause_send_q, pause_send_d;
  logic [NUM_PRI-1:0] pri_req_q, pri_req_d;
  logic [NUM_PRI-1:0] pri_pend_q, pri_pend_d;
  logic pfc_send_q, pfc_send_d;
  logic [NUM_PRI-1:0] pfc_vec_q, pfc_vec_d;
  logic pause_rise;
  logic [NUM_PRI-1:0] pri_rise;

  assign pause_rise = !PFC_ENABLE && pause_req && !pause_req_q; // see (R8)
  assign pri_rise = PFC_ENABLE ? (tx_priority_pause_request_n & ~pri_req_q) : '0; // see (R7)

  always_comb
  begin
    pause_req_d = pause_req;
    pri_req_d = tx_priority_pause_request_n;
    pause_param_d = pause_param_q;
    if (pause_rise)
    begin
      pause_param_d = pause_val; // see (R5) (R15)
    end
    // a new request in the grant cycle stays pending
    pause_pend_d = (pause_pend_q && !(tx_ctrl_grant && pause_send_q)) || pause_rise;
    pause_send_d = pause_pend_q && !(tx_ctrl_grant && pause_send_q)
                   && (pause_send_q || !tx_frame_active); // see (R4)
    pri_pend_d = (pri_pend_q & ~((tx_ctrl_grant && pfc_send_q) ? pfc_vec_q : '0)) | pri_rise;
    pfc_vec_d = pfc_vec_q;
    pfc_send_d = pfc_send_q;
    if (pfc_send_q && tx_ctrl_grant)
    begin
      pfc_send_d = 1'b0;
    end
    else if (!pfc_send_q && pri_pend_q != '0 && !tx_frame_active)
    begin
      pfc_send_d = 1'b1; // see (R10)
      pfc_vec_d = pri_pend_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pause_req_q <= 1'b0;
      pause_pend_q <= 1'b0;
      pause_param_q <= '0;
      pause_send_q <= 1'b0;
      pri_req_q <= '0;
      pri_pend_q <= '0;
      pfc_send_q <= 1'b0;
      pfc_vec_q <= '0;
    end
    else
    begin
      pause_req_q <= pause_req_d;
      pause_pend_q <= pause_pend_d;
      pause_param_q <= pause_param_d;
      pause_send_q <= pause_send_d;
      pri_req_q <= pri_req_d;
      pri_pend_q <= pri_pend_d;
      pfc_send_q <= pfc_send_d;
      pfc_vec_q <= pfc_vec_d;
    end
  end

  assign tx_pause_send = pause_send_q;
  assign tx_pause_param = pause_param_q;
  assign tx_pfc_send = pfc_send_q;
  assign tx_pfc_vector = pfc_vec_q;

  // ==========================================================
  // receive side pause timers
  logic legacy_busy;
  logic [NUM_PRI-1:0] pri_busy;
  logic inhibit_q, inhibit_d;
  logic drop_q, drop_d;
  logic [NUM_PRI-1:0] ind_q, ind_d;
  logic [NUM_PRI-1:0] pri_load;

  assign pri_load = {NUM_PRI{pfc_hit}} & rx_frame_pri_enable;

  quanta_timer legacy_timer
  (
    .clk(clk),
    .rst_n(rst_n),
    .load(legacy_hit),
    .quanta(rx_frame_quanta),
    .run(1'b1),
    .busy(legacy_busy)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PRI; gi++)
    begin : g_pri // see (R9)
      quanta_timer pri_timer
      (
        .clk(clk),
        .rst_n(rst_n),
        .load(pri_load[gi]),
        .quanta(rx_frame_pri_quanta[gi*flow_pkg::QUANTA_W +: flow_pkg::QUANTA_W]),
        .run(rx_priority_pause_ack_n[gi]), // see (R12) (R13)
        .busy(pri_busy[gi])
      );
    end
  endgenerate

  always_comb
  begin
    inhibit_d = legacy_busy; // see (R2)
    drop_d = legacy_hit || pfc_hit; // see (R3)
    ind_d = pri_busy; // see (R11) (R16)
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inhibit_q <= 1'b0;
      drop_q <= 1'b0;
      ind_q <= '0;
    end
    else
    begin
      inhibit_q <= inhibit_d;
      drop_q <= drop_d;
      ind_q <= ind_d;
    end
  end

  assign tx_inhibit = inhibit_q;
  assign rx_frame_drop = drop_q;
  assign rx_priority_pause_indication_n = ind_q;

  // ==========================================================
  // checks
  sequence s_pause_rx;
    legacy_hit && rx_frame_quanta != flow_pkg::QUANTA_ZERO;
  endsequence

  sequence s_pfc_req(int i);
    (PFC_ENABLE && $rose(tx_priority_pause_request_n[i]) && !pfc_send_q && pri_pend_q == '0)
    ##1 !tx_frame_active;
  endsequence

  sequence s_pause_grant;
    tx_pause_send && tx_ctrl_grant;
  endsequence

  sequence s_pfc_grant;
    tx_pfc_send && tx_ctrl_grant;
  endsequence

  pause_capture_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R15)
    pause_rise |=> tx_pause_param == $past(pause_val))
    else $error("pause value not captured with request");

  pause_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R4)
    $rose(tx_pause_send) |-> $past(!tx_frame_active))
    else $error("pause frame started during data packet");

  pause_send_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R4)
    pause_rise && !pause_pend_q ##1 !tx_frame_active |=> tx_pause_send)
    else $error("pause request not sent");

  inhibit_start_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R2)
    s_pause_rx |-> ##2 tx_inhibit [*8])
    else $error("transmitter not inhibited after pause frame");

  inhibit_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R1)
    !tx_inhibit && rx_frame_done && !cfg_rx_fc_enable |=> ##1 !$rose(tx_inhibit))
    else $error("pause acted on while disabled");

  frame_filter_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R14)
    rx_frame_done && !rx_frame_good |=> !rx_frame_drop)
    else $error("errored frame treated as control frame");

  drop_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R3)
    (legacy_hit || pfc_hit) |=> rx_frame_drop)
    else $error("acted frame not flagged for discard");

  mutual_excl_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R8)
    PFC_ENABLE ? (!tx_pause_send && !tx_inhibit) : (!tx_pfc_send && ind_q == '0))
    else $error("legacy and priority mechanisms both active");

  pause_grant_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R4)
    s_pause_grant |=> !tx_pause_send)
    else $error("pause frame request kept after grant");

  pause_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R4)
    tx_pause_send && !tx_ctrl_grant |=> tx_pause_send)
    else $error("pause frame request dropped before grant");

  pfc_grant_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R10)
    s_pfc_grant |=> !tx_pfc_send)
    else $error("priority frame request kept after grant");

  pfc_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R10)
    tx_pfc_send && !tx_ctrl_grant |=> tx_pfc_send && $stable(tx_pfc_vector))
    else $error("priority frame request changed before grant");

  pfc_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R10)
    $rose(tx_pfc_send) |-> $past(!tx_frame_active))
    else $error("priority frame started during data packet");

  drop_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R3)
    rx_frame_drop |-> $past(rx_frame_done))
    else $error("discard flag without finished frame");

  inhibit_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R2)
    legacy_hit && rx_frame_quanta == flow_pkg::QUANTA_ZERO |-> ##2 !tx_inhibit)
    else $error("zero pause time kept transmitter inhibited");

  generate
    for (gi = 0; gi < NUM_PRI; gi++)
    begin : g_chk
      pfc_request_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R10)
        s_pfc_req(gi) |=> tx_pfc_send && tx_pfc_vector[gi])
        else $error("priority request not sent");

      ack_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R12)
        (pfc_hit && rx_frame_pri_enable[gi]
         && rx_frame_pri_quanta[gi*flow_pkg::QUANTA_W +: flow_pkg::QUANTA_W] != '0)
        ##1 (!rx_priority_pause_ack_n[gi]) [*8] |=> rx_priority_pause_indication_n[gi])
        else $error("priority quanta expired without acknowledge");

      ind_track_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R11) (R16)
        ($rose(rx_priority_pause_indication_n[gi]) && !$past(pri_load[gi]) && !pri_load[gi])
        ##1 (!pri_load[gi]) [*7] |=> rx_priority_pause_indication_n[gi])
        else $error("priority pause dropped within a quantum");
    end
  endgenerate
endmodule

/* tb/fifo_partner.sv */
`timescale 1ns/10ps
// ==========================================================
// per-priority rx fifo: acknowledges a pause after delay cycles
module fifo_partner
(
  input wire logic clk,
  input wire logic [7:0] pause_ind,
  input wire logic hold,
  input wire logic [7:0] delay,
  output logic [7:0] ack
);
  logic [7:0] cnt_q [8];
  initial ack = 8'h00;
  always @(negedge clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      cnt_q[i] <= pause_ind[i] ? cnt_q[i] + {7'h00, cnt_q[i] != 8'hff} : 8'h00;
      // unused handshake held high
      ack[i] <= hold || (pause_ind[i] && cnt_q[i] >= delay);
    end
  end
endmodule

/* tb/test_mac_flow_control_pause.sv */
`timescale 1ns/10ps
module test_mac_flow_control_pause;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic fc_en = 1'b1;
  logic [47:0] src = 48'h02aabbccddee;
  logic pause_req = 1'b0;
  logic [15:0] pause_val = 16'h0000;
  logic active = 1'b0;
  logic grant = 1'b0;
  logic done = 1'b0;
  logic good = 1'b0;
  logic [47:0] da = 48'h000000000000;
  logic [15:0] ltype = 16'h0000;
  logic [15:0] opcode = 16'h0000;
  logic [15:0] quanta = 16'h0000;
  logic [7:0] pen = 8'h00;
  logic [7:0] tx_req = 8'h00;
  logic hold = 1'b0;
  logic [7:0] delay = 8'h14;
  logic [7:0] ack;
  logic l_send, l_psend, l_inh, l_drop, p_send, p_psend, p_inh, p_drop;
  logic [15:0] l_param, p_param;
  logic [7:0] l_vec, p_vec, l_ind, p_ind;
  int fails = 0;
  int tests_run = 0;

  always #4 clk = ~clk;

  // ==========================================================
  // legacy build and priority build on shared stimulus
  mac_flow_control_pause #(.PFC_ENABLE(1'b0)) i_dut
  (
    .clk(clk), .arst_n(arst_n), .cfg_rx_fc_enable(fc_en), .cfg_src_addr(src),
    .pause_req(pause_req), .pause_val(pause_val), .tx_frame_active(active),
    .tx_ctrl_grant(grant), .rx_frame_done(done), .rx_frame_good(good), .rx_frame_da(da),
    .rx_frame_ltype(ltype), .rx_frame_opcode(opcode), .rx_frame_quanta(quanta),
    .rx_frame_pri_enable(pen), .rx_frame_pri_quanta({8{quanta}}),
    .tx_priority_pause_request_n(tx_req), .rx_priority_pause_ack_n(ack),
    .tx_pause_send(l_send), .tx_pause_param(l_param), .tx_pfc_send(l_psend),
    .tx_pfc_vector(l_vec), .tx_inhibit(l_inh), .rx_frame_drop(l_drop),
    .rx_priority_pause_indication_n(l_ind)
  );
  mac_flow_control_pause #(.PFC_ENABLE(1'b1)) i_dut_pfc
  (
    .clk(clk), .arst_n(arst_n), .cfg_rx_fc_enable(fc_en), .cfg_src_addr(src),
    .pause_req(pause_req), .pause_val(pause_val), .tx_frame_active(active),
    .tx_ctrl_grant(grant), .rx_frame_done(done), .rx_frame_good(good), .rx_frame_da(da),
    .rx_frame_ltype(ltype), .rx_frame_opcode(opcode), .rx_frame_quanta(quanta),
    .rx_frame_pri_enable(pen), .rx_frame_pri_quanta({8{quanta}}),
    .tx_priority_pause_request_n(tx_req), .rx_priority_pause_ack_n(ack),
    .tx_pause_send(p_send), .tx_pause_param(p_param), .tx_pfc_send(p_psend),
    .tx_pfc_vector(p_vec), .tx_inhibit(p_inh), .rx_frame_drop(p_drop),
    .rx_priority_pause_indication_n(p_ind)
  );
  fifo_partner i_fifo (.clk(clk), .pause_ind(p_ind), .hold(hold), .delay(delay), .ack(ack));

  // ==========================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic do_grant();
    grant = 1'b1;
    cyc(1);
    grant = 1'b0;
  endtask

  task automatic rx_frame(input logic g, input logic [47:0] a, input logic [15:0] lt,
                          input logic [15:0] op, input logic [15:0] q);
    done = 1'b1;
    good = g;
    da = a;
    ltype = lt;
    opcode = op;
    quanta = q;
    cyc(1);
    done = 1'b0;
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_pause_tx();
    active = 1'b1;
    pause_req = 1'b1;
    pause_val = 16'h1234;
    cyc(1);
    pause_req = 1'b0;
    pause_val = 16'hffff;
    cyc(2);
    chk(l_param === 16'h1234, "value not taken with request");
    pause_req = 1'b1;
    pause_val = 16'h5a5a;
    cyc(4);
    chk(l_send === 1'b0, "pause sent during packet");
    active = 1'b0;
    for (int i = 0; i < 6 && l_send !== 1'b1; i++)
      cyc(1);
    chk(l_send === 1'b1 && l_param === 16'h5a5a, "pause frame value");
    chk(p_send === 1'b0 && p_param === 16'h0000, "pause from priority build");
    cyc(2);
    chk(l_send === 1'b1, "pause dropped before grant");
    do_grant();
    cyc(3);
    chk(l_send === 1'b0, "held request sent twice");
    pause_req = 1'b0;
    cyc(1);
    pause_req = 1'b1;
    pause_val = 16'h0042;
    cyc(2);
    chk(l_send === 1'b1 && l_param === 16'h0042, "idle pause not sent");
    do_grant();
    pause_req = 1'b0;
    $display("test pause_tx finished");
  endtask

  task automatic t_rx_pause();
    int n;
    rx_frame(1'b1, flow_pkg::CTRL_MCAST, flow_pkg::CTRL_LTYPE, flow_pkg::PAUSE_OPCODE, 16'h0002);
    chk(l_drop === 1'b1, "no drop flag");
    cyc(1);
    chk(l_drop === 1'b0 && l_inh === 1'b1, "no inhibit");
    n = 1;
    while (l_inh === 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk(n >= 128 && n <= 131, "inhibit length");
    rx_frame(1'b1, src, flow_pkg::CTRL_LTYPE, flow_pkg::PAUSE_OPCODE, 16'h0004);
    cyc(10);
    chk(l_inh === 1'b1, "own address frame ignored");
    rx_frame(1'b1, src, flow_pkg::CTRL_LTYPE, flow_pkg::PAUSE_OPCODE, 16'h0000);
    cyc(3);
    chk(l_inh === 1'b0, "zero quanta kept pause");
    $display("test rx_pause finished");
  endtask

  task automatic t_rx_filter();
    for (int k = 0; k < 5; k++)
    begin
      fc_en = (k != 4);
      rx_frame(k != 0, (k == 1) ? 48'h0180c2000002 : src,
               (k == 2) ? 16'h0800 : flow_pkg::CTRL_LTYPE,
               (k == 3) ? 16'h0002 : flow_pkg::PAUSE_OPCODE, 16'h0008);
      chk(l_drop === 1'b0, "bad frame flagged");
      cyc(2);
      chk(l_inh === 1'b0, "bad frame acted on");
    end
    fc_en = 1'b1;
    $display("test rx_filter finished");
  endtask

  task automatic t_pfc_tx();
    tx_req = 8'h81;
    for (int i = 0; i < 6 && p_psend !== 1'b1; i++)
      cyc(1);
    chk(p_psend === 1'b1 && p_vec === 8'h81, "priority frame vector");
    chk(l_psend === 1'b0 && l_vec === 8'h00, "priority frame from legacy build");
    tx_req = 8'hff;
    cyc(2);
    chk(p_vec === 8'h81, "vector changed while pending");
    do_grant();
    for (int i = 0; i < 6 && p_psend !== 1'b1; i++)
      cyc(1);
    chk(p_psend === 1'b1 && p_vec === 8'h7e, "second priority frame");
    do_grant();
    tx_req = 8'h00;
    cyc(2);
    chk(p_psend === 1'b0, "priority frame not cleared");
    $display("test pfc_tx finished");
  endtask

  task automatic t_pfc_rx();
    int n;
    for (int k = 0; k < 2; k++)
    begin
      hold = (k == 1);
      pen = 8'h08;
      rx_frame(1'b1, flow_pkg::CTRL_MCAST, flow_pkg::CTRL_LTYPE, flow_pkg::PFC_OPCODE, 16'h0001);
      pen = 8'h00;
      chk(p_drop === 1'b1, "no drop flag");
      cyc(1);
      chk(p_ind === 8'h08, "indication to fifo");
      n = 1;
      while (p_ind[3] === 1'b1 && n < 300)
      begin
        cyc(1);
        n++;
      end
      chk(n >= (k ? 64 : 84) && n <= (k ? 67 : 90), "indication length");
    end
    hold = 1'b0;
    $display("test pfc_rx finished");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    cyc(3);
    chk({l_send, l_psend, l_inh, l_drop, l_ind, p_send, p_psend, p_inh, p_drop, p_ind}
        === 24'h000000, "outputs active at idle");
    t_pause_tx();
    t_rx_pause();
    t_rx_filter();
    t_pfc_tx();
    t_pfc_rx();
    test_done();
  end

  // about 360 cycles expected, about ten times that allowed
  initial
  begin
    #(8 * 3500);
    fails++;
    test_done();
  end
endmodule
